// file: rtl/scl_step_ctrl.sv
// Control inputs, current selection, fault latch and status outputs of the stage.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module scl_step_ctrl #(
	parameter int CYCLES_MS = scl_pkg::CYCLES_PER_MS
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Indexer inputs, raw pin levels.
	input wire logic stepPin,
	input wire logic dirPin,
	input wire logic raisePin,
	input wire logic driveOffPin,
	input wire logic resetPin,
	input wire logic downshiftPin,
	// Switch settings.
	input wire logic swNegLogic,
	input wire logic swErrOpen,
	input wire logic swPrefDir,
	input wire logic [2:0] swResolution,
	// Fault sensors.
	input wire logic faultUnderVolt,
	input wire logic faultOverCurr,
	input wire logic faultOverTemp,
	// Power stage and status outputs.
	output logic driveEnable,
	output logic runCurrent,
	output logic raiseActive,
	output logic [5:0] raiseLevel,
	output logic raiseProgrammed,
	output logic [6:0] ringPos,
	output logic [2:0] activeRes,
	output logic homeMark,
	output logic errContactClosed,
	output logic ready
);

	// ==========================================================
	// Declarations.
	typedef enum logic {stWaitReady, stOperate} scl_state_type;
	localparam int READY_CYCLES = scl_pkg::READY_DELAY_MS * CYCLES_MS;
	localparam int SW_DELAY_CYCLES = scl_pkg::SW_DELAY_MS * CYCLES_MS;

	scl_state_type state_q;
	logic [31:0] ctrl_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic stepPrev_q;
	logic fault_q;
	logic resLocked_q;
	scl_pkg::scl_res_type res_q;
	logic [24:0] readyCnt_q;
	logic driveEn_q;
	logic home_q;
	logic errClosed_q;
	logic busMode, negLogic, errOpen, prefDir;
	logic stepAct, dirAct, raiseAct, driveOffAct, resetAct, downshiftAct;
	logic stepEdge, stepAcc, clearReq, faultAny, softReset, delayDone, wbWrite;
	scl_pkg::scl_res_type resReq;
	logic [24:0] delayLoad;

	// Active level of a pin under the chosen logic sense.
	function automatic logic activeLevel(input logic pin, input logic neg);
		activeLevel = pin ^ neg;
	endfunction

	// ==========================================================
	// Configuration source: switches or bus register.
	assign busMode = ctrl_q[scl_pkg::CTRL_BUS_MODE_BIT];
	assign negLogic = busMode ? ctrl_q[scl_pkg::CTRL_NEG_LOGIC_BIT] : swNegLogic;
	assign errOpen = busMode ? ctrl_q[scl_pkg::CTRL_ERR_OPEN_BIT] : swErrOpen;
	assign prefDir = busMode ? ctrl_q[scl_pkg::CTRL_PREF_DIR_BIT] : swPrefDir;

	// Pin decoding; drive-off and reset use the inverted sense the switch or bus register defines.
	assign stepAct = activeLevel(stepPin, negLogic);
	assign dirAct = activeLevel(dirPin, negLogic);
	assign raiseAct = activeLevel(raisePin, negLogic);
	assign driveOffAct = !activeLevel(driveOffPin, negLogic);
	assign resetAct = !activeLevel(resetPin, negLogic);
	assign downshiftAct = !downshiftPin;

	// ==========================================================
	// Step detection and qualification.
	// A rising active level is one step; synchronous inputs at 20 MHz catch any
	// pulse of 1 us or more, well inside the 750 kHz rate.
	assign stepEdge = stepAct && !stepPrev_q;
	assign stepAcc = stepEdge && state_q == stOperate && driveEn_q && !fault_q;
	assign softReset = wbWrite && wb_adr_i == scl_pkg::ADDR_CTRL && wb_sel_i[0]
		&& wb_dat_i[scl_pkg::CTRL_SOFT_RESET_BIT];
	assign clearReq = resetAct || softReset;
	assign faultAny = faultUnderVolt || faultOverCurr || faultOverTemp;

	// Previous active step level for edge detection.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stepPrev_q <= 1'b0;
		end else begin
			stepPrev_q <= stepAct;
		end
	end

	// ==========================================================
	// Resolution: requested setting, coarsened by the downshift input.
	always_comb begin
		resReq = busMode ? scl_pkg::scl_res_type'(ctrl_q[scl_pkg::CTRL_RES_LSB +: 3])
			: scl_pkg::scl_res_type'(swResolution);
		if (downshiftAct && resReq != scl_pkg::full_step) begin
			resReq = scl_pkg::scl_res_type'(resReq - 3'h1);
		end
	end

	// Resolution follows the request until the first accepted step after reset.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			resLocked_q <= 1'b0;
			res_q <= scl_pkg::full_step;
		end else if (clearReq) begin
			resLocked_q <= 1'b0;
			res_q <= resReq;
		end else begin
			if (stepAcc) begin
				resLocked_q <= 1'b1;
			end
			if (!resLocked_q && !stepAcc) begin
				res_q <= resReq;
			end
		end
	end

	// ==========================================================
	// Ready sequencing after reset.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= stWaitReady;
			readyCnt_q <= 25'h0;
		end else if (clearReq) begin
			state_q <= stWaitReady;
			readyCnt_q <= 25'h0;
		end else begin
			unique case (state_q)
				stWaitReady: begin
					readyCnt_q <= readyCnt_q + 25'h1;
					if (readyCnt_q == 25'(READY_CYCLES - 1)) begin
						state_q <= stOperate;
					end
				end
				stOperate: begin
					readyCnt_q <= 25'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Fault latch; a new fault wins over a clear in the same cycle.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			fault_q <= 1'b0;
		end else if (faultAny) begin
			fault_q <= 1'b1;
		end else if (clearReq) begin
			fault_q <= 1'b0;
		end
	end

	// Drive enable, home mark and error contact outputs.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			driveEn_q <= 1'b0;
			home_q <= 1'b1;
			errClosed_q <= 1'b0;
		end else begin
			driveEn_q <= !driveOffAct && !fault_q && !faultAny;
			home_q <= (ringPos == 7'h0);
			errClosed_q <= errOpen ? fault_q : !fault_q;
		end
	end

	// ==========================================================
	// Ring counter and current delay timer.
	scl_ring_counter u_ring (
		.clock(clock),
		.nrst(nrst),
		.clear(clearReq),
		.advance(stepAcc),
		.up(dirAct ^ prefDir),
		.modulo(scl_pkg::ringModulo(res_q)),
		.position(ringPos)
	);

	// Fixed delay on switches, table setting when on the bus.
	assign delayLoad = busMode
		? 25'(scl_pkg::delayMs(ctrl_q[scl_pkg::CTRL_DELAY_LSB +: 4]) * 25'(CYCLES_MS))
		: 25'(SW_DELAY_CYCLES);

	scl_delay_timer u_delay (
		.clock(clock),
		.nrst(nrst),
		.load(stepAcc),
		.loadValue(delayLoad),
		.expired(delayDone)
	);

	// ==========================================================
	// Current selection and status outputs.
	assign driveEnable = driveEn_q;
	assign runCurrent = !delayDone;
	assign raiseActive = raiseAct && driveEn_q;
	assign raiseProgrammed = busMode;
	assign raiseLevel = busMode ? ctrl_q[scl_pkg::CTRL_BOOST_LSB +: 6]
		: scl_pkg::BOOST_SW_PERCENT;
	assign activeRes = res_q;
	assign homeMark = home_q;
	assign errContactClosed = errClosed_q;
	assign ready = (state_q == stOperate);

	// ==========================================================
	// Wishbone slave: one wait state, unmapped reads give zero.
	assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

	// Acknowledge and read data.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			unique case (wb_adr_i)
				scl_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
				scl_pkg::ADDR_STATUS: rdata_q <= {17'h0, res_q, driveEn_q, !delayDone,
					fault_q, ready, 1'b0, ringPos};
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	// Control register writes; the soft reset bit never stores.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ctrl_q <= scl_pkg::CTRL_RESET;
		end else if (wbWrite && wb_adr_i == scl_pkg::ADDR_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
			ctrl_q[scl_pkg::CTRL_SOFT_RESET_BIT] <= 1'b0;
			ctrl_q[31:18] <= 14'h0;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence sResetStart;
		clearReq && !faultAny;
	endsequence

	sequence sHomeAndClear;
		ringPos == 7'h0 && !fault_q && !ready;
	endsequence

	a_step_advances: assert property (stepAcc && !clearReq |=> ringPos != $past(ringPos))
		else $error("Accepted step did not move the ring counter.");
	a_run_on_step: assert property (stepAcc && !clearReq |=> runCurrent)
		else $error("Run current not selected after a step.");
	a_step_blocked: assert property (stepEdge && !stepAcc && !clearReq
		|=> ringPos == $past(ringPos))
		else $error("Blocked step moved the ring counter.");
	a_drive_off: assert property (driveOffAct |=> !driveEnable)
		else $error("Drive stayed enabled while deactivated.");
	a_fault_latch: assert property (faultAny |=> fault_q && !driveEnable ##1 !driveEnable)
		else $error("Fault not latched or drive not disabled.");
	a_fault_hold: assert property (fault_q && !clearReq |=> fault_q)
		else $error("Fault cleared without a reset.");
	a_reset_home: assert property (sResetStart |=> sHomeAndClear)
		else $error("Reset did not return home and clear faults.");
	a_ready_wait: assert property (clearReq ##1 !clearReq |-> !ready [*2])
		else $error("Ready given too early after reset.");
	a_home_mark: assert property (##1 homeMark == ($past(ringPos) == 7'h0))
		else $error("Home mark does not follow ring zero.");
	a_error_sense: assert property (nrst |=> errContactClosed ==
		($past(errOpen) ? $past(fault_q) : !$past(fault_q)))
		else $error("Error contact sense wrong.");
	a_downshift: assert property (nrst && !resLocked_q && !clearReq && !stepAcc && downshiftAct
		&& resReq != scl_pkg::full_step |=> res_q == $past(resReq))
		else $error("Downshifted resolution not taken.");

endmodule

// file: rtl/scl_pkg.sv
// Shared constants, types and helpers for the stepper control input logic.
package scl_pkg;

	// ==========================================================
	// Register map.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0700;

	// ==========================================================
	// Control register field positions.
	localparam int CTRL_BUS_MODE_BIT = 0;
	localparam int CTRL_NEG_LOGIC_BIT = 1;
	localparam int CTRL_ERR_OPEN_BIT = 2;
	localparam int CTRL_PREF_DIR_BIT = 3;
	localparam int CTRL_SOFT_RESET_BIT = 4;
	localparam int CTRL_RES_LSB = 5;
	localparam int CTRL_DELAY_LSB = 8;
	localparam int CTRL_BOOST_LSB = 12;

	// ==========================================================
	// Status register field positions.
	localparam int STAT_RING_LSB = 0;
	localparam int STAT_READY_BIT = 8;
	localparam int STAT_FAULT_BIT = 9;
	localparam int STAT_RUN_BIT = 10;
	localparam int STAT_DRIVE_BIT = 11;
	localparam int STAT_RES_LSB = 12;

	// ==========================================================
	// Timing constants.
	localparam int CLOCK_HZ = 20_000_000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int SW_DELAY_MS = 40;
	localparam int READY_DELAY_MS = 500;
	localparam int STEP_MAX_KHZ = 750;
	localparam int STEP_MIN_WIDTH_NS = 1000;
	localparam logic [5:0] BOOST_SW_PERCENT = 6'h1e;

	// ==========================================================
	// Step resolutions, coarsest first.
	typedef enum logic [2:0] {
		full_step, half_step, step_2p5, step_4, step_5, step_8, step_10, step_20
	} scl_res_type;

	// Pulses per electrical cycle of each resolution.
	function automatic logic [6:0] ringModulo(input scl_res_type res);
		unique case (res)
			full_step: ringModulo = 7'h04;
			half_step: ringModulo = 7'h08;
			step_2p5: ringModulo = 7'h0a;
			step_4: ringModulo = 7'h10;
			step_5: ringModulo = 7'h14;
			step_8: ringModulo = 7'h20;
			step_10: ringModulo = 7'h28;
			step_20: ringModulo = 7'h50;
		endcase
	endfunction

	// Programmable current delay in ms; setting zero behaves as setting one.
	function automatic logic [9:0] delayMs(input logic [3:0] idx);
		unique case (idx)
			4'h0, 4'h1: delayMs = 10'h001;
			4'h2: delayMs = 10'h002;
			4'h3: delayMs = 10'h005;
			4'h4: delayMs = 10'h00a;
			4'h5: delayMs = 10'h014;
			4'h6: delayMs = 10'h01e;
			4'h7: delayMs = 10'h028;
			4'h8: delayMs = 10'h032;
			4'h9: delayMs = 10'h064;
			4'ha: delayMs = 10'h0c8;
			4'hb: delayMs = 10'h12c;
			4'hc: delayMs = 10'h190;
			4'hd: delayMs = 10'h1f4;
			4'he: delayMs = 10'h2ee;
			4'hf: delayMs = 10'h3e8;
		endcase
	endfunction

endpackage

// file: rtl/scl_delay_timer.sv
// Countdown timer that reports when a loaded interval has run out.
`timescale 1ns/10ps
module scl_delay_timer (
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Load and status.
	input wire logic load,
	input wire logic [24:0] loadValue,
	output logic expired
);

	logic [24:0] count_q;

	// Reload on every trigger, otherwise count down to zero and stay there.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			count_q <= 25'h0;
		end else if (load) begin
			count_q <= loadValue;
		end else if (count_q != 25'h0) begin
			count_q <= count_q - 25'h1;
		end
	end

	assign expired = (count_q == 25'h0);

	a_load_restart: assert property (@(posedge clock) disable iff (!nrst)
		load && loadValue > 25'h1 |=> !expired)
		else $error("Timer expired right after a load.");

endmodule

// file: rtl/scl_ring_counter.sv
// Phase ring counter that wraps at the pulse count of one electrical cycle.
`timescale 1ns/10ps
module scl_ring_counter (
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Control.
	input wire logic clear,
	input wire logic advance,
	input wire logic up,
	input wire logic [6:0] modulo,
	// Position.
	output logic [6:0] position
);

	logic [6:0] pos_q;

	// Clear to home, else step up or down modulo the cycle length.
	always_ff @(posedge clock) begin
		if (!nrst || clear) begin
			pos_q <= 7'h0;
		end else if (advance) begin
			if (up) begin
				pos_q <= (pos_q >= modulo - 7'h1) ? 7'h0 : pos_q + 7'h1;
			end else begin
				pos_q <= (pos_q == 7'h0) ? modulo - 7'h1 : pos_q - 7'h1;
			end
		end
	end

	assign position = pos_q;

	a_ring_wrap: assert property (@(posedge clock) disable iff (!nrst)
		advance && !clear && up && pos_q == modulo - 7'h1 |=> pos_q == 7'h0)
		else $error("Ring counter did not wrap to home.");

endmodule

// file: test/scl_indexer_model.sv
// Indexer model that drives step pulses and the direction line of the stage.
`timescale 1ns/10ps
module scl_indexer_model (
	// Clock and polarity.
	input wire logic clock,
	input wire logic negLogic,
	// Indexer lines.
	output logic stepPin,
	output logic dirPin
);
	// ==========================================================
	// Pulse generation.

	// Step line starts at its positive-logic idle level, direction line at its active level.
	initial begin
		stepPin = 1'b0;
		dirPin = 1'b1;
	end

	// Parks the step line at its inactive level after a polarity change.
	task automatic idle();
		@(posedge clock);
		stepPin <= negLogic;
	endtask

	// Issues one step; a new direction is settled well ahead of the active edge.
	task automatic step(input logic up);
		if (dirPin !== (up ^ negLogic)) begin
			repeat (81) @(posedge clock); // Axis at rest, last edge over 4 us back.
			dirPin <= up ^ negLogic;
			repeat (81) @(posedge clock); // Direction held over 4 us around edges.
		end
		@(posedge clock);
		stepPin <= ~negLogic;
		repeat (21) @(posedge clock); // Active level held over 1 us.
		stepPin <= negLogic;
		repeat (21) @(posedge clock); // Inactive gap keeps the rate low.
	endtask
endmodule

// file: test/scl_step_ctrl_tb.sv
// Self-checking testbench for the stepper control input logic.
`timescale 1ns/10ps
module scl_step_ctrl_tb;
	// ==========================================================
	// Signals.
	localparam int MS = 10;
	logic clock, nrst, wbCyc, wbStb, wbWe, wbAck, raisePin, driveOffPin, resetPin;
	logic downshiftPin, stepPin, dirPin, negLogic, swErrOpen, swPrefDir, driveEnable;
	logic runCurrent, raiseActive, raiseProgrammed, homeMark, errContactClosed, ready;
	logic [3:0] wbAdr, wbSel, busSel;
	logic [31:0] wbDat, wbDatO, rd;
	logic [2:0] swResolution, activeRes, faults;
	logic [5:0] raiseLevel;
	logic [6:0] ringPos;
	int n_errors = 0;
	int checks = 0;

	// ==========================================================
	// Design, indexer and clock.
	scl_step_ctrl #(.CYCLES_MS(MS)) i_dut (
		.clock(clock), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .stepPin(stepPin), .dirPin(dirPin), .raisePin(raisePin),
		.driveOffPin(driveOffPin), .resetPin(resetPin), .downshiftPin(downshiftPin),
		.swNegLogic(negLogic), .swErrOpen(swErrOpen), .swPrefDir(swPrefDir),
		.swResolution(swResolution), .faultUnderVolt(faults[0]), .faultOverCurr(faults[1]),
		.faultOverTemp(faults[2]), .driveEnable(driveEnable), .runCurrent(runCurrent),
		.raiseActive(raiseActive), .raiseLevel(raiseLevel), .raiseProgrammed(raiseProgrammed),
		.ringPos(ringPos), .activeRes(activeRes), .homeMark(homeMark),
		.errContactClosed(errContactClosed), .ready(ready)
	);
	scl_indexer_model i_idx (.clock(clock), .negLogic(negLogic), .stepPin(stepPin),
		.dirPin(dirPin));

	// Free-running 20 MHz clock.
	always #25 clock = ~clock;

	// ==========================================================
	// Shared tasks.

	// Compares one value and counts the outcome.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One classic bus cycle, held until the acknowledge is sampled.
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
			output logic [31:0] data);
		int i;
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= busSel;
		wbDat <= dat;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (wbAck === 1'b1) break;
		end
		data = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (i == 20) begin
			check("ack wait", 1'b0, 1'b1);
			print_verdict();
		end
	endtask

	// Waits for ready, which must take close to the full settling time.
	task automatic waitReady();
		int i;
		for (i = 0; i < 520 * MS && ready !== 1'b1; i++) @(posedge clock);
		if (ready !== 1'b1) begin
			check("ready wait", 1'b0, 1'b1);
			print_verdict();
		end
		check("ready time", i >= 490 * MS, 1'b1);
	endtask

	// ==========================================================
	// Scenarios.

	// Reset values, bus refusal and steps ignored before ready.
	task automatic test_reset();
		check("homeMark", homeMark, 1'b1);
		check("ready", ready, 1'b0);
		wb(1'b0, scl_pkg::ADDR_CTRL, 32'h0, rd);
		check("ctrl", rd, scl_pkg::CTRL_RESET);
		wb(1'b1, 4'h8, 32'hffff_ffff, rd);
		wb(1'b0, 4'h8, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		wb(1'b0, scl_pkg::ADDR_CTRL, 32'h0, rd);
		check("ctrl kept", rd, scl_pkg::CTRL_RESET);
		busSel = 4'h4;
		wb(1'b1, scl_pkg::ADDR_CTRL, 32'hffff_ff00, rd);
		busSel = 4'hf;
		wb(1'b0, scl_pkg::ADDR_CTRL, 32'h0, rd);
		check("ctrl byte", rd, 32'h0003_0700);
		wb(1'b1, scl_pkg::ADDR_CTRL, scl_pkg::CTRL_RESET, rd);
		i_idx.step(1'b1);
		check("ringPos early", ringPos, 7'h0);
		waitReady();
		$display("test reset done");
	endtask

	// Ten steps up wrap the coarser ring once; run current then times out.
	task automatic test_steps();
		int k;
		for (k = 1; k <= 10; k++) begin
			i_idx.step(1'b1);
			check("ringPos up", ringPos, k % 10);
			check("homeMark", homeMark, k == 10);
			check("runCurrent", runCurrent, 1'b1);
		end
		check("activeRes", activeRes, scl_pkg::step_2p5);
		check("raiseActive", raiseActive, 1'b1);
		check("raiseLevel", raiseLevel, scl_pkg::BOOST_SW_PERCENT);
		check("raiseProgrammed", raiseProgrammed, 1'b0);
		repeat (300) @(posedge clock);
		check("run held", runCurrent, 1'b1);
		repeat (100) @(posedge clock);
		check("stop current", runCurrent, 1'b0);
		$display("test steps done");
	endtask

	// Direction line and preferred direction both turn the count round.
	task automatic test_dir();
		i_idx.step(1'b0);
		check("ringPos down", ringPos, 7'h9);
		swPrefDir <= 1'b1;
		repeat (81) @(posedge clock);
		i_idx.step(1'b0);
		check("ringPos pref", ringPos, 7'h0);
		swPrefDir <= 1'b0;
		$display("test dir done");
	endtask

	// Drive-off at standstill removes current and blocks steps.
	task automatic test_driveoff();
		driveOffPin <= 1'b0; // Asserted only with the axis at rest.
		repeat (3) @(posedge clock);
		check("drive off", driveEnable, 1'b0);
		check("raise off", raiseActive, 1'b0);
		i_idx.step(1'b1);
		check("ringPos held", ringPos, 7'h0);
		driveOffPin <= 1'b1;
		repeat (3) @(posedge clock);
		check("drive on", driveEnable, 1'b1);
		$display("test driveoff done");
	endtask

	// Each fault source latches, opens the contact (closes it for the second source, run with swErrOpen set) and needs the reset input.
	task automatic test_faults();
		int k;
		for (k = 0; k < 3; k++) begin
			swErrOpen <= (k == 1);
			i_idx.step(1'b1);
			check("contact idle", errContactClosed, k != 1);
			faults <= 3'h1 << k;
			repeat (2) @(posedge clock);
			faults <= 3'h0;
			repeat (3) @(posedge clock);
			check("contact fault", errContactClosed, k == 1);
			check("drive fault", driveEnable, 1'b0);
			wb(1'b0, scl_pkg::ADDR_STATUS, 32'h0, rd);
			check("status fault", rd[scl_pkg::STAT_FAULT_BIT], 1'b1);
			i_idx.step(1'b1);
			check("ringPos frozen", ringPos, 7'h1);
			resetPin <= 1'b0;
			swResolution <= (k == 2) ? 3'h0 : 3'h3;
			repeat (4) @(posedge clock);
			check("ringPos home", ringPos, 7'h0);
			resetPin <= 1'b1;
			repeat (4) @(posedge clock);
			check("contact cleared", errContactClosed, k != 1);
			check("homeMark reset", homeMark, 1'b1);
			check("activeRes reset", activeRes, (k == 2) ? scl_pkg::full_step : scl_pkg::step_2p5);
			waitReady();
		end
		$display("test faults done");
	endtask

	// Bus mode with negative logic, full step, programmed delay and raise level.
	task automatic test_bus();
		resetPin <= 1'b0;
		driveOffPin <= 1'b0;
		downshiftPin <= 1'b1; // Changed only while held in reset.
		raisePin <= 1'b0;
		@(posedge clock);
		negLogic <= 1'b1;
		i_idx.idle();
		wb(1'b1, scl_pkg::ADDR_CTRL, 32'h0002_a403, rd);
		wb(1'b0, scl_pkg::ADDR_CTRL, 32'h0, rd);
		check("ctrl bus", rd, 32'h0002_a403);
		waitReady();
		check("raiseLevel bus", raiseLevel, 6'h2a);
		check("raiseProgrammed", raiseProgrammed, 1'b1);
		check("raise low", raiseActive, 1'b1);
		repeat (5) i_idx.step(1'b1);
		wb(1'b0, scl_pkg::ADDR_STATUS, 32'h0, rd);
		check("status ringPos", rd[6:0], 7'h1);
		check("activeRes bus", activeRes, scl_pkg::full_step);
		repeat (43) @(posedge clock);
		check("bus run held", runCurrent, 1'b1);
		repeat (25) @(posedge clock);
		check("bus stop", runCurrent, 1'b0);
		faults <= 3'h4;
		repeat (2) @(posedge clock);
		faults <= 3'h0;
		repeat (2) @(posedge clock);
		check("bus fault", driveEnable, 1'b0);
		wb(1'b1, scl_pkg::ADDR_CTRL, 32'h0002_a413, rd);
		wb(1'b0, scl_pkg::ADDR_STATUS, 32'h0, rd);
		check("bus reset fault", rd[scl_pkg::STAT_FAULT_BIT], 1'b0);
		check("bus reset home", rd[6:0], 7'h0);
		check("bus reset ready", rd[scl_pkg::STAT_READY_BIT], 1'b0);
		$display("test bus done");
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 4'h0;
		wbSel = 4'h0;
		busSel = 4'hf;
		wbDat = 32'h0;
		raisePin = 1'b1;
		driveOffPin = 1'b1;
		resetPin = 1'b1;
		downshiftPin = 1'b0; // Set before the first step after reset.
		negLogic = 1'b0;
		swErrOpen = 1'b0;
		swPrefDir = 1'b0;
		swResolution = 3'h3;
		faults = 3'h0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		test_reset();
		test_steps();
		test_dir();
		test_driveoff();
		test_faults();
		test_bus();
		print_verdict();
	end
endmodule
